/* rtl/bbm_core.sv */
`timescale 1ns/1ps
// Functional notes
// - alias write bit0 one sets target bit
// - alias write ignores data bits 31:1
// - alias read returns zero or one
// - bytes ascending, words little-endian
// - load-exclusive reads and sets tag
// - store-exclusive writes only when tag held
// - clear-exclusive drops the tag
// - any store-exclusive drops the tag
// - exception entry drops the tag
// - exclusives in byte, half, word sizes
// - alias word maps byte*32 plus bit*4
// - alias write is read-modify-write
module bbm_core (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // request from load/store path
    input bbm_pkg::bbm_req_t req,
    output logic reqReady,
    // answer to load/store path
    output bbm_pkg::bbm_rsp_t rsp,
    // exception entry
    input wire logic excEntry,
    // monitor state
    output logic exclTag
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic isAlias(input logic [31:0] a);
        isAlias = ((a & bbm_pkg::ALIAS_SPAN_MASK) ==
            bbm_pkg::SRAM_ALIAS_BASE) ||
            ((a & bbm_pkg::ALIAS_SPAN_MASK) == bbm_pkg::PERI_ALIAS_BASE);
    endfunction : isAlias

    // byte offset = alias offset / 32, bit = (offset / 4) mod 8
    function automatic logic [31:0] bandByte(input logic [31:0] a);
        bandByte = {a[31:28], 8'h00, 20'h0_0000} |
            {12'h000, a[bbm_pkg::BYTE_OFS_LSB +: bbm_pkg::BYTE_OFS_W]};
    endfunction : bandByte

    function automatic logic [3:0] laneMask(input bbm_pkg::bbm_size_t s,
            input logic [1:0] a);
        case (s)
            bbm_pkg::SZ_BYTE: laneMask = 4'h1 << a;
            bbm_pkg::SZ_HALF: laneMask = a[1] ? 4'hC : 4'h3;
            default: laneMask = 4'hF;
        endcase
    endfunction : laneMask

    // bit position in the band word: the lane picks the byte
    function automatic logic [4:0] bitIndex(input logic [1:0] lane,
            input logic [2:0] b);
        bitIndex = {lane, b};
    endfunction : bitIndex

    // narrow reads come back right-aligned, zeros above
    function automatic logic [31:0] laneData(
            input bbm_pkg::bbm_size_t z, input logic [31:0] w,
            input logic [1:0] lane);
        logic [31:0] sh;
        sh = w >> {lane, 3'b000};
        case (z)
            bbm_pkg::SZ_BYTE: laneData = {24'h00_0000, sh[7:0]};
            bbm_pkg::SZ_HALF: laneData = {16'h0000, sh[15:0]};
            default: laneData = w;
        endcase
    endfunction : laneData

    function automatic logic opWrites(input bbm_pkg::bbm_op_t o);
        opWrites = (o == bbm_pkg::OP_STORE) ||
            (o == bbm_pkg::OP_STORE_EXCL);
    endfunction : opWrites

    function automatic logic opExcl(input bbm_pkg::bbm_op_t o);
        opExcl = (o == bbm_pkg::OP_LOAD_EXCL) ||
            (o == bbm_pkg::OP_STORE_EXCL);
    endfunction : opExcl

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        bbm_pkg::bbm_state_t st;
        logic tag;
        logic isAl;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        bbm_pkg::bbm_size_t size;
        logic excl;
        bbm_pkg::bbm_rsp_t rsp;
    } bbm_core_t;

    bbm_core_t s;
    bbm_core_t next_s;
    logic memWe;
    logic [3:0] memBe;
    logic [31:0] memWdata;
    logic [31:0] memRdata;
    logic [2:0] bitSel;
    logic [1:0] bLane;

    // ------------------------------------------------------------
    // memory
    // ------------------------------------------------------------
    // one shared array stands for both band regions: only addr[11:2] counts
    // read address runs one step ahead so the word is there in READ
    bbm_mem u_mem (
        .clk(clk),
        .we(memWe),
        .be(memBe),
        .waddr(s.addr[bbm_pkg::MEM_AW+1:2]),
        .wdata(memWdata),
        .raddr(next_s.addr[bbm_pkg::MEM_AW+1:2]),
        .rdata(memRdata)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reqReady = (s.st == bbm_pkg::ST_IDLE);
    assign rsp = s.rsp;
    assign exclTag = s.tag;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rsp.valid = 1'b0;
        memWe = 1'b0;
        memBe = 4'h0;
        memWdata = bbm_pkg::WORD_ZERO;
        bitSel = s.addr[bbm_pkg::BIT_SEL_LSB +: 3];
        bLane = s.addr[1:0];
        case (s.st)
            bbm_pkg::ST_IDLE: begin
                if (req.valid && req.op == bbm_pkg::OP_CLEAR_EXCL) begin
                    // nothing to read or write, so it answers next cycle
                    next_s.tag = 1'b0;
                    next_s.rsp = '{valid: 1'b1, rdata: '0, status: 1'b0};
                end else if (req.valid) begin
                    next_s.isAl = isAlias(req.addr);
                    next_s.addr = next_s.isAl ? bandByte(req.addr)
                        : req.addr;
                    if (next_s.isAl) begin
                        // address becomes the band byte: bit select is dropped here
                        next_s.addr = bandByte(req.addr);
                    end
                    next_s.wdata = req.wdata;
                    next_s.size = next_s.isAl ? bbm_pkg::SZ_WORD : req.size;
                    next_s.write = opWrites(req.op);
                    next_s.excl = opExcl(req.op);
                    next_s.st = bbm_pkg::ST_READ;
                    if (req.op == bbm_pkg::OP_LOAD_EXCL) begin
                        next_s.tag = 1'b1;
                    end
                    if (req.op == bbm_pkg::OP_STORE_EXCL) begin
                        // fail when no reservation: no write at all
                        // fixed at take: a later exception cannot flip it
                        next_s.rsp.status = ~s.tag;
                        next_s.write = s.tag;
                        next_s.tag = 1'b0;
                    end else begin
                        next_s.rsp.status = 1'b0;
                    end
                    // bit select is lost in bandByte, keep it in wdata bits 5:3
                    if (next_s.isAl) begin
                        next_s.wdata = {26'h000_0000,
                            req.addr[bbm_pkg::BIT_SEL_LSB +: 3],
                            2'b00, req.wdata[0]};
                    end
                end
            end
            bbm_pkg::ST_READ: begin
                next_s.st = bbm_pkg::ST_MODIFY;
            end
            bbm_pkg::ST_MODIFY: begin
                next_s.st = bbm_pkg::ST_DONE;
                if (s.isAl) begin
                    bitSel = s.wdata[5:3];
                    // byte lane from band byte address
                    next_s.rsp.rdata = memRdata[bitIndex(bLane, bitSel)]
                        ? bbm_pkg::WORD_ONE : bbm_pkg::WORD_ZERO;
                    if (s.write) begin
                        memWe = 1'b1;
                        memBe = 4'hF;
                        memWdata = memRdata;
                        memWdata[bitIndex(bLane, bitSel)] = s.wdata[0];
                    end
                end else begin
                    // width follows access size
                    memBe = laneMask(s.size, bLane);
                    memWdata = s.wdata << {bLane, 3'b000};
                    memWe = s.write;
                    next_s.rsp.rdata = laneData(s.size, memRdata, bLane);
                end
            end
            bbm_pkg::ST_DONE: begin
                next_s.rsp.valid = 1'b1;
                next_s.st = bbm_pkg::ST_IDLE;
            end
            default: next_s.st = bbm_pkg::ST_IDLE;
        endcase
        // last word on the tag: an exception beats a load-exclusive
        if (excEntry) begin
            next_s.tag = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.st <= bbm_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end
endmodule : bbm_core

/* rtl/bbm_pkg.sv */
package bbm_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;
    localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
    localparam logic [31:0] ALIAS_SPAN_MASK = 32'hFE00_0000;
    localparam int BIT_SEL_LSB = 2;
    localparam int BYTE_OFS_LSB = 5;
    localparam int BYTE_OFS_W = 20;
    localparam int MEM_AW = 10;

    // ------------------------------------------------------------
    // access kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } bbm_size_t;

    typedef enum logic [2:0] {
        OP_LOAD = 3'h0,
        OP_STORE = 3'h1,
        OP_LOAD_EXCL = 3'h2,
        OP_STORE_EXCL = 3'h3,
        OP_CLEAR_EXCL = 3'h4
    } bbm_op_t;

    typedef struct packed {
        logic valid;
        bbm_op_t op;
        bbm_size_t size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bbm_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
        logic status;
    } bbm_rsp_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_MODIFY = 4'b0100,
        ST_DONE = 4'b1000
    } bbm_state_t;

    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_ONE = 32'h0000_0001;

endpackage : bbm_pkg

/* rtl/bbm_mem.sv */
`timescale 1ns/1ps
module bbm_mem (
    // clock
    input wire logic clk,
    // port
    input wire logic we,
    input wire logic [3:0] be,
    input wire logic [bbm_pkg::MEM_AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [bbm_pkg::MEM_AW-1:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] mem [0:(1<<bbm_pkg::MEM_AW)-1];

    // byte lane k holds byte address 4*word+k: little-endian
    always_ff @(posedge clk) begin
        for (int k = 0; k < 4; k++) begin
            if (we && be[k]) begin
                mem[waddr][8*k +: 8] <= wdata[8*k +: 8];
            end
        end
        rdata <= mem[raddr];
    end
endmodule : bbm_mem

/* sim/bbm_host.sv */
`timescale 1ns/1ps
module bbm_host (
    // clock
    input wire logic clk,
    // load/store side of the core
    output bbm_pkg::bbm_req_t req,
    input wire logic reqReady,
    input bbm_pkg::bbm_rsp_t rsp
);
    logic [31:0] rd;
    logic st;
    logic late;
    initial req = '0;
    // callers pair sizes; only the exception test retries a failed store-exclusive
    task automatic issue(input bbm_pkg::bbm_req_t r);
        int n;
        bbm_pkg::bbm_req_t idle;
        @(negedge clk);
        req = r;
        n = 0;
        // ready follows state only, so it is settled at the falling edge
        while (reqReady !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        // taken at this rising edge, released at the next falling one
        @(posedge clk);
        @(negedge clk);
        // released lines show the inverse, never the old value
        idle = ~r;
        idle.valid = 1'b0;
        req = idle;
        while (rsp.valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        late = (n >= 20);
        rd = rsp.rdata;
        st = rsp.status;
    endtask : issue
endmodule : bbm_host

/* sim/bbm_core_asserts.sv */
`timescale 1ns/1ps
module bbm_core_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched ports
    input bbm_pkg::bbm_req_t req,
    input wire logic reqReady,
    input bbm_pkg::bbm_rsp_t rsp,
    input wire logic excEntry,
    input wire logic exclTag
);
    logic tk;
    logic tkSx;
    logic tkLx;
    assign tk = req.valid && reqReady;
    assign tkSx = tk && req.op == bbm_pkg::OP_STORE_EXCL;
    assign tkLx = tk && req.op == bbm_pkg::OP_LOAD_EXCL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ans;
        tk && req.op != bbm_pkg::OP_CLEAR_EXCL |-> ##[3:4] rsp.valid;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_lx;
        tkLx && !excEntry |-> ##[1:4] exclTag;
    endproperty
    a_lx: assert property (p_lx) else $error("tag not set");
    property p_clr;
        tk && req.op == bbm_pkg::OP_CLEAR_EXCL |-> ##[1:2] !exclTag;
    endproperty
    a_clr: assert property (p_clr) else $error("clear kept tag");
    property p_sx;
        tkSx |-> ##[1:4] !exclTag;
    endproperty
    a_sx: assert property (p_sx) else $error("store kept tag");
    // only while idle with no request: a load-exclusive sets the tag when taken, not later
    property p_exc;
        excEntry && reqReady && !req.valid |=> !exclTag;
    endproperty
    a_exc: assert property (p_exc) else $error("exception kept tag");
    property p_fail;
        tkSx && !exclTag |-> ##[3:4] (rsp.valid && rsp.status);
    endproperty
    a_fail: assert property (p_fail) else $error("should fail");
    property p_ok;
        tkSx && exclTag && !excEntry |-> ##[3:4] (rsp.valid && !rsp.status);
    endproperty
    a_ok: assert property (p_ok) else $error("should pass");
    property p_pulse;
        rsp.valid && !tk |=> !rsp.valid && reqReady;
    endproperty
    a_pulse: assert property (p_pulse) else $error("answer too long");
    c_fail: cover property (tkSx && !exclTag);
    c_ok: cover property (tkSx && exclTag);
    c_exc: cover property (excEntry && exclTag);
endmodule : bbm_core_asserts
bind bbm_core bbm_core_asserts chk_u (.clk(clk), .nrst(nrst), .req(req),
    .reqReady(reqReady), .rsp(rsp), .excEntry(excEntry), .exclTag(exclTag));

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [2:0] op;
        logic [1:0] sz;
        logic [31:0] a;
        logic [31:0] v;
        logic s;
    } bbm_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic excEntry = 1'b0;
    logic reqReady;
    logic exclTag;
    bbm_pkg::bbm_req_t req;
    bbm_pkg::bbm_rsp_t rsp;
    int err_total = 0;
    int n_checks = 0;
    // op 0 load 1 store 2 ld-excl 3 st-excl 4 clear; v is data or expect
    bbm_row_t rows [23] = '{
        '{3'h1, 2'h2, 32'h2000_0004, 32'h1122_3344, 1'b0},
        '{3'h0, 2'h0, 32'h2000_0005, 32'h0000_0033, 1'b0},
        '{3'h0, 2'h1, 32'h2000_0006, 32'h0000_1122, 1'b0},
        '{3'h1, 2'h2, 32'h2200_0088, 32'h0000_000E, 1'b0},
        '{3'h1, 2'h2, 32'h2200_00BC, 32'h0000_00FF, 1'b0},
        '{3'h0, 2'h2, 32'h2000_0004, 32'h1122_B340, 1'b0},
        '{3'h0, 2'h2, 32'h2200_00BC, 32'h0000_0001, 1'b0},
        '{3'h0, 2'h2, 32'h2200_0088, 32'h0000_0000, 1'b0},
        '{3'h1, 2'h2, 32'h2000_0010, 32'hAABB_CCDD, 1'b0},
        '{3'h2, 2'h0, 32'h2000_0011, 32'h0000_00CC, 1'b0},
        '{3'h3, 2'h0, 32'h2000_0011, 32'h0000_0055, 1'b0},
        '{3'h3, 2'h0, 32'h2000_0011, 32'h0000_0066, 1'b1},
        '{3'h0, 2'h2, 32'h2000_0010, 32'hAABB_55DD, 1'b0},
        '{3'h2, 2'h1, 32'h2000_0012, 32'h0000_AABB, 1'b0},
        '{3'h4, 2'h2, 32'h2000_0012, 32'h0000_0000, 1'b0},
        '{3'h3, 2'h1, 32'h2000_0012, 32'h0000_1234, 1'b1},
        '{3'h2, 2'h2, 32'h2000_0010, 32'hAABB_55DD, 1'b0},
        '{3'h2, 2'h2, 32'h2000_0010, 32'hAABB_55DD, 1'b0},
        '{3'h3, 2'h2, 32'h2000_0010, 32'h0000_0000, 1'b0},
        '{3'h1, 2'h2, 32'h4000_0020, 32'h0000_0000, 1'b0},
        '{3'h1, 2'h2, 32'h4200_0454, 32'h0000_0003, 1'b0},
        '{3'h0, 2'h2, 32'h4000_0020, 32'h0020_0000, 1'b0},
        '{3'h0, 2'h2, 32'h4200_0454, 32'h0000_0001, 1'b0}};
    always #50 clk = ~clk;
    bbm_core dut_u (.clk(clk), .nrst(nrst), .req(req), .reqReady(reqReady),
        .rsp(rsp), .excEntry(excEntry), .exclTag(exclTag));
    bbm_host host_u (.clk(clk), .req(req), .reqReady(reqReady), .rsp(rsp));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk32
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: flag %b want %b", $time, g, e);
        end
    endtask : chk1
    task automatic run(input bbm_row_t r);
        host_u.issue(bbm_pkg::bbm_req_t'{1'b1, bbm_pkg::bbm_op_t'(r.op),
            bbm_pkg::bbm_size_t'(r.sz), r.a, r.v});
        if (host_u.late) begin
            err_total++;
            $display("unexpected at %0t: no answer", $time);
            report_and_stop();
        end
    endtask : run
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        chk1(exclTag, 1'b0);
        chk1(reqReady, 1'b1);
        foreach (rows[i]) begin
            run(rows[i]);
            if (rows[i].op == 3'h0 || rows[i].op == 3'h2) begin
                chk32(host_u.rd, rows[i].v);
            end
            if (rows[i].op == 3'h3) begin
                chk1(host_u.st, rows[i].s);
            end
        end
        $display("test done: table");
        run(bbm_row_t'{3'h2, 2'h2, 32'h2000_0010, 32'h0000_0000, 1'b0});
        chk1(exclTag, 1'b1);
        @(negedge clk);
        excEntry = 1'b1;
        @(negedge clk);
        excEntry = 1'b0;
        chk1(exclTag, 1'b0);
        run(bbm_row_t'{3'h3, 2'h2, 32'h2000_0010, 32'h0000_0009, 1'b0});
        chk1(host_u.st, 1'b1);
        run(bbm_row_t'{3'h0, 2'h2, 32'h2000_0010, 32'h0000_0000, 1'b0});
        chk32(host_u.rd, 32'h0000_0000);
        // a failed store is retried from the load, as software must
        run(bbm_row_t'{3'h2, 2'h2, 32'h2000_0010, 32'h0000_0000, 1'b0});
        chk32(host_u.rd, 32'h0000_0000);
        run(bbm_row_t'{3'h3, 2'h2, 32'h2000_0010, 32'h0000_0009, 1'b0});
        chk1(host_u.st, 1'b0);
        run(bbm_row_t'{3'h0, 2'h2, 32'h2000_0010, 32'h0000_0000, 1'b0});
        chk32(host_u.rd, 32'h0000_0009);
        $display("test done: exception");
        run(bbm_row_t'{3'h2, 2'h2, 32'h2000_0010, 32'h0000_0000, 1'b0});
        chk32(host_u.rd, 32'h0000_0009);
        chk1(exclTag, 1'b1);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        chk1(exclTag, 1'b0);
        chk1(reqReady, 1'b1);
        run(bbm_row_t'{3'h3, 2'h2, 32'h2000_0010, 32'h0000_0007, 1'b0});
        chk1(host_u.st, 1'b1);
        run(bbm_row_t'{3'h0, 2'h2, 32'h2000_0010, 32'h0000_0000, 1'b0});
        chk32(host_u.rd, 32'h0000_0009);
        $display("test done: reset");
        report_and_stop();
    end
endmodule : testbench
